// >>> tap_pkg.sv
// constants, types and state encodings for the sram boundary-scan test port
// Behaviour
// - the port holds a 3-bit instruction register, a 32-bit identification register, a 1-bit bypass and a 109-cell chain.
// - identification bits 31:29 hold the revision, 28:12 the device type and 11:1 the maker code.
// - identification bit 0 is always 1 to show that the register exists.
// - code 000 captures the input and output ring into the boundary chain.
// - code 001 loads the fixed identification code and shifts it between tdi and tdo.
// - code 010 captures the ring, shifts the boundary chain and forces every sram output driver to high impedance.
// - code 100 captures the ring and shifts the boundary chain without disturbing normal sram operation.
// - code 111 places the single-bit bypass between tdi and tdo.
// - under the identification or bypass instruction normal reads and writes are untouched.
// - the identification instruction is selected at power-up and on every tck rise taken in test-logic-reset.
// - the most significant chain cell sits next to tdi and the least significant next to tdo.
// - under code 000 the latched cell 108 enables the read-data drivers when high and floats them when low.
// - a shifted instruction takes effect only in update-ir, never while shifting.
package tap_pkg;

    // ------------------------------------------------------------
    // register sizes
    // ------------------------------------------------------------
    localparam int IR_W     = 3;
    localparam int ID_W     = 32;
    localparam int BSR_W    = 109;
    localparam int RING_W   = 108;
    localparam int TRI_CELL = 108;

    // ------------------------------------------------------------
    // identification field layout and fixed values
    // ------------------------------------------------------------
    localparam int ID_REV_LSB   = 29;
    localparam int ID_PART_LSB  = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam int ID_PRESENT   = 0;
    localparam logic [2:0]  ID_REV_DEF   = 3'h1;       // value is arbitrary
    localparam logic [16:0] ID_PART_DEF  = 17'h0a5a5;  // value is arbitrary
    localparam logic [10:0] ID_MAKER_DEF = 11'h2aa;    // value is arbitrary

    // ------------------------------------------------------------
    // reset and capture values
    // ------------------------------------------------------------
    localparam logic [2:0] IR_CAPTURE = 3'h1;   // fixed 01 pattern in the low bits
    localparam logic       TRI_RESET  = 1'h0;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        INS_EXTEST  = 3'b000,
        INS_IDCODE  = 3'b001,
        INS_SAMPLEZ = 3'b010,
        INS_RSVD3   = 3'b011,
        INS_SAMPLE  = 3'b100,
        INS_RSVD5   = 3'b101,
        INS_RSVD6   = 3'b110,
        INS_BYPASS  = 3'b111
    } instr_e;

    // ------------------------------------------------------------
    // tap controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET   = 4'b0000,
        ST_IDLE    = 4'b0001,
        ST_SEL_DR  = 4'b0010,
        ST_CAP_DR  = 4'b0011,
        ST_SH_DR   = 4'b0100,
        ST_EX1_DR  = 4'b0101,
        ST_PAU_DR  = 4'b0110,
        ST_EX2_DR  = 4'b0111,
        ST_UPD_DR  = 4'b1000,
        ST_SEL_IR  = 4'b1001,
        ST_CAP_IR  = 4'b1010,
        ST_SH_IR   = 4'b1011,
        ST_EX1_IR  = 4'b1100,
        ST_PAU_IR  = 4'b1101,
        ST_EX2_IR  = 4'b1110,
        ST_UPD_IR  = 4'b1111
    } tap_state_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_s;

    typedef struct packed {
        tap_state_e state;
    } fsm_state_s;

endpackage

// >>> tap_fsm.sv
// sixteen-state test access controller stepped by sampled tck rising edges
module tap_fsm (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // sampled link
    input  wire logic              tck_rise,
    input  wire logic              tms,
    // controller state
    output tap_pkg::tap_state_e    state
);

    tap_pkg::fsm_state_s st_r;
    tap_pkg::fsm_state_s st_nxt;

    assign state = st_r.state;

    // next state taken only on a rising tck edge
    always_comb begin
        st_nxt = st_r;
        if (tck_rise) begin
            case (st_r.state)
                tap_pkg::ST_RESET:  st_nxt.state = tms ? tap_pkg::ST_RESET  : tap_pkg::ST_IDLE;
                tap_pkg::ST_IDLE:   st_nxt.state = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_DR: st_nxt.state = tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
                tap_pkg::ST_CAP_DR: st_nxt.state = tms ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_SH_DR:  st_nxt.state = tms ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_EX1_DR: st_nxt.state = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAU_DR;
                tap_pkg::ST_PAU_DR: st_nxt.state = tms ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PAU_DR;
                tap_pkg::ST_EX2_DR: st_nxt.state = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_UPD_DR: st_nxt.state = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_IR: st_nxt.state = tms ? tap_pkg::ST_RESET  : tap_pkg::ST_CAP_IR;
                tap_pkg::ST_CAP_IR: st_nxt.state = tms ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_SH_IR:  st_nxt.state = tms ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_EX1_IR: st_nxt.state = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAU_IR;
                tap_pkg::ST_PAU_IR: st_nxt.state = tms ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PAU_IR;
                tap_pkg::ST_EX2_IR: st_nxt.state = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_UPD_IR: st_nxt.state = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                default:            st_nxt.state = tap_pkg::ST_RESET;
            endcase
        end
    end

    // power-up lands in test-logic-reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r.state <= tap_pkg::ST_RESET;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

endmodule // tap_fsm

// >>> sram_boundary_scan_tap.sv
// boundary-scan test access port of a burst sram, run from the core clock
module sram_boundary_scan_tap #(
    parameter logic [2:0]  ID_REV   = tap_pkg::ID_REV_DEF,
    parameter logic [16:0] ID_PART  = tap_pkg::ID_PART_DEF,
    parameter logic [10:0] ID_MAKER = tap_pkg::ID_MAKER_DEF
) (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    // test link pins
    input  wire logic                          tck,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output logic                               tdo,
    output logic                               tdo_oe,
    // boundary ring
    input  wire logic [tap_pkg::RING_W-1:0]    ring_in,
    output logic      [tap_pkg::RING_W-1:0]    ring_drive,
    output logic                               ring_drive_en,
    // sram read-data output control
    output logic                               q_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        tap_pkg::tap_pins_s            pin_s1;
        tap_pkg::tap_pins_s            pin_s2;
        logic                          tck_prev;
        logic [tap_pkg::RING_W-1:0]    ring_s1;
        logic [tap_pkg::RING_W-1:0]    ring_s2;
        logic [tap_pkg::IR_W-1:0]      ir_sr;
        tap_pkg::instr_e               ir_act;
        logic [tap_pkg::BSR_W-1:0]     dr_sr;
        logic [tap_pkg::BSR_W-1:0]     bsr_upd;
        logic                          tdo;
        logic                          tdo_oe;
        logic [tap_pkg::RING_W-1:0]    ring_drive;
        logic                          ring_drive_en;
        logic                          q_oe;
    } tap_s;

    tap_s                  st_r;
    tap_s                  st_nxt;
    tap_pkg::tap_state_e   tap_state;
    logic                  tck_rise;
    logic                  tck_fall;
    logic [tap_pkg::ID_W-1:0] id_word;

    // ------------------------------------------------------------
    // fixed identification word
    // ------------------------------------------------------------
    // field positions follow the package layout; bit 0 is a hard one
    assign id_word = {ID_REV, ID_PART, ID_MAKER, 1'b1};

    // edges are found on the second synchroniser stage only
    assign tck_rise = st_r.pin_s2.tck & ~st_r.tck_prev;
    assign tck_fall = ~st_r.pin_s2.tck & st_r.tck_prev;

    // ------------------------------------------------------------
    // controller
    // ------------------------------------------------------------
    tap_fsm u_fsm (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .tck_rise (tck_rise),
        .tms      (st_r.pin_s2.tms),
        .state    (tap_state)
    );

    // ------------------------------------------------------------
    // datapath next state
    // ------------------------------------------------------------
    // every action keys off the controller state seen before the edge,
    // matching how a tck-clocked port would act on that same edge
    always_comb begin
        st_nxt          = st_r;
        st_nxt.pin_s1   = tap_pkg::tap_pins_s'{tck: tck, tms: tms, tdi: tdi};
        st_nxt.pin_s2   = st_r.pin_s1;
        st_nxt.tck_prev = st_r.pin_s2.tck;
        // ring pins are synchronised too; a ring moving during capture may mix old and new bits
        st_nxt.ring_s1  = ring_in;
        st_nxt.ring_s2  = st_r.ring_s1;

        // rising tck: capture, shift and update
        if (tck_rise) begin
            case (tap_state)
                tap_pkg::ST_RESET: begin
                    st_nxt.ir_act                    = tap_pkg::INS_IDCODE;
                    st_nxt.bsr_upd[tap_pkg::TRI_CELL] = tap_pkg::TRI_RESET;
                end
                tap_pkg::ST_CAP_IR: begin
                    st_nxt.ir_sr = tap_pkg::IR_CAPTURE;
                end
                tap_pkg::ST_SH_IR: begin
                    // only the shift stage moves; the active code holds
                    st_nxt.ir_sr = {st_r.pin_s2.tdi, st_r.ir_sr[tap_pkg::IR_W-1:1]};
                end
                tap_pkg::ST_UPD_IR: begin
                    st_nxt.ir_act = tap_pkg::instr_e'(st_r.ir_sr);
                end
                tap_pkg::ST_CAP_DR: begin
                    case (st_r.ir_act)
                        tap_pkg::INS_EXTEST,
                        tap_pkg::INS_SAMPLEZ,
                        tap_pkg::INS_SAMPLE: begin
                            // the internal cell reports its own latched value
                            st_nxt.dr_sr = {st_r.bsr_upd[tap_pkg::TRI_CELL], st_r.ring_s2};
                        end
                        tap_pkg::INS_IDCODE: begin
                            st_nxt.dr_sr = {{(tap_pkg::BSR_W-tap_pkg::ID_W){1'b0}}, id_word};
                        end
                        default: begin
                            // bypass and the unused codes capture a zero
                            st_nxt.dr_sr = '0;
                        end
                    endcase
                end
                tap_pkg::ST_SH_DR: begin
                    case (st_r.ir_act)
                        tap_pkg::INS_EXTEST,
                        tap_pkg::INS_SAMPLEZ,
                        tap_pkg::INS_SAMPLE: begin
                            // tdi enters the top cell, bit 0 leaves toward tdo
                            st_nxt.dr_sr = {st_r.pin_s2.tdi, st_r.dr_sr[tap_pkg::BSR_W-1:1]};
                        end
                        tap_pkg::INS_IDCODE: begin
                            st_nxt.dr_sr[tap_pkg::ID_W-1:0] =
                                {st_r.pin_s2.tdi, st_r.dr_sr[tap_pkg::ID_W-1:1]};
                        end
                        default: begin
                            st_nxt.dr_sr[0] = st_r.pin_s2.tdi;
                        end
                    endcase
                end
                tap_pkg::ST_UPD_DR: begin
                    // preload only for the chain instructions
                    if (st_r.ir_act == tap_pkg::INS_EXTEST || st_r.ir_act == tap_pkg::INS_SAMPLEZ ||
                        st_r.ir_act == tap_pkg::INS_SAMPLE) begin
                        st_nxt.bsr_upd = st_r.dr_sr;
                    end
                end
                default: begin
                end
            endcase
        end

        // falling tck: present the outgoing bit
        if (tck_fall) begin
            st_nxt.tdo_oe = (tap_state == tap_pkg::ST_SH_IR) || (tap_state == tap_pkg::ST_SH_DR);
            st_nxt.tdo    = (tap_state == tap_pkg::ST_SH_IR) ? st_r.ir_sr[0] : st_r.dr_sr[0];
        end

        // pin control follows the active instruction and the preload
        st_nxt.ring_drive    = st_nxt.bsr_upd[tap_pkg::RING_W-1:0];
        st_nxt.ring_drive_en = (st_nxt.ir_act == tap_pkg::INS_EXTEST);
        case (st_nxt.ir_act)
            tap_pkg::INS_EXTEST:  st_nxt.q_oe = st_nxt.bsr_upd[tap_pkg::TRI_CELL];
            tap_pkg::INS_SAMPLEZ: st_nxt.q_oe = 1'b0;
            default:              st_nxt.q_oe = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // clk_en low freezes everything, the synchronisers included
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r.pin_s1        <= '0;
            st_r.pin_s2        <= '0;
            st_r.tck_prev      <= 1'b0;
            st_r.ring_s1       <= '0;
            st_r.ring_s2       <= '0;
            st_r.ir_sr         <= tap_pkg::IR_CAPTURE;
            st_r.ir_act        <= tap_pkg::INS_IDCODE;
            st_r.dr_sr         <= '0;
            st_r.bsr_upd       <= '0;
            st_r.tdo           <= 1'b0;
            st_r.tdo_oe        <= 1'b0;
            st_r.ring_drive    <= '0;
            st_r.ring_drive_en <= 1'b0;
            st_r.q_oe          <= 1'b1;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tdo           = st_r.tdo;
    assign tdo_oe        = st_r.tdo_oe;
    assign ring_drive    = st_r.ring_drive;
    assign ring_drive_en = st_r.ring_drive_en;
    assign q_oe          = st_r.q_oe;

endmodule // sram_boundary_scan_tap

// >>> tap_asserts.sv
// concurrent checks on the pins of the boundary-scan test port
module tap_asserts (
    // clock and reset
    input wire logic                        core_clk,
    input wire logic                        rst_n,
    input wire logic                        clk_en,
    // link and outputs
    input wire logic                        tck,
    input wire logic                        tdo,
    input wire logic                        tdo_oe,
    input wire logic [tap_pkg::RING_W-1:0] ring_drive,
    input wire logic                        ring_drive_en,
    input wire logic                        q_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // reset leaves the drivers enabled, the link quiet and the preload clear
    AST_RST_IDLE: assert property (disable iff (1'b0) !rst_n && clk_en |=>
        !tdo_oe && q_oe && !ring_drive_en && ring_drive == '0) else $error("reset values wrong");
    // tdo only moves once a tck fall has passed the synchroniser
    AST_TDO_FALL: assert property ($changed(tdo) |-> !$past(tck) && !$past(tck, 2))
        else $error("tdo moved outside a tck low phase");
    AST_OE_FALL: assert property ($changed(tdo_oe) |-> !$past(tck) && !$past(tck, 2))
        else $error("tdo_oe moved outside a tck low phase");
    // a tck period spans at least eight core cycles, so the enable cannot flicker
    AST_OE_HOLD: assert property ($rose(tdo_oe) |=> $stable(tdo_oe) [*6])
        else $error("tdo_oe did not stand");
    // instruction and preload effects land only just after a detected tck rise
    AST_QOE_RISE: assert property ($changed(q_oe) && $past(rst_n) |-> $past(tck, 2))
        else $error("q_oe changed away from a tck rise");
    AST_DREN_RISE: assert property ($changed(ring_drive_en) && $past(rst_n) |-> $past(tck, 2))
        else $error("ring_drive_en changed away from a tck rise");
    AST_RING_RISE: assert property ($changed(ring_drive) && $past(rst_n) |-> $past(tck, 2))
        else $error("ring_drive changed away from a tck rise");
    // a low enable freezes sampling, so tdo, tdo_oe and q_oe may not move
    AST_FREEZE: assert property (!clk_en |=> $stable(tdo) && $stable(tdo_oe) && $stable(q_oe))
        else $error("outputs moved while frozen");

    // main scenarios
    cover property ($fell(q_oe));
    cover property ($rose(ring_drive_en));
    cover property ($rose(tdo_oe));
endmodule // tap_asserts

bind sram_boundary_scan_tap tap_asserts i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
    .ring_drive(ring_drive), .ring_drive_en(ring_drive_en), .q_oe(q_oe));

// >>> jtag_host_model.sv
// board-side test controller model that walks the tap state machine
module jtag_host_model (
    // link pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    logic got;

    // tck stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one 64 ns period: pins move while tck is low, tdo is taken late in the low phase
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #4;
        tck = 1'b1;
        #32;
        tck = 1'b0;
        #28;
        got = tdo;
    endtask

    // idle to a shift state, n bits lsb first, parked in exit1; spare tdi toggles
    task automatic scan(input logic ir, input int n, input logic [108:0] din, output logic [108:0] dout);
        dout = '0;
        step(1'b1, ~tdi);
        if (ir)
            step(1'b1, ~tdi);
        step(1'b0, ~tdi);
        step(1'b0, ~tdi);
        dout[0] = got;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            if (i < n - 1)
                dout[i + 1] = got;
        end
    endtask

    // exit1 to update, then the rise out of update applies it
    task automatic upd();
        step(1'b1, ~tdi);
        step(1'b0, ~tdi);
    endtask

    // tms high for six rises reaches test-logic-reset from anywhere
    task automatic tlr();
        repeat (6) step(1'b1, ~tdi);
        step(1'b0, ~tdi);
    endtask
endmodule // jtag_host_model

// >>> sram_boundary_scan_tap_tb.sv
// self-checking bench for the boundary-scan test port
module sram_boundary_scan_tap_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [107:0] PAT = {9{12'ha5c}};
    localparam logic [31:0] ID_EXP = {tap_pkg::ID_REV_DEF, tap_pkg::ID_PART_DEF, tap_pkg::ID_MAKER_DEF, 1'b1};
    logic         core_clk, rst_n, clk_en, tck, tms, tdi, tdo, tdo_oe, ring_drive_en, q_oe;
    logic [107:0] ring_in, ring_drive;
    logic [108:0] res;
    int           n_errors, total_checks;

    sram_boundary_scan_tap i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_drive(ring_drive),
        .ring_drive_en(ring_drive_en), .q_oe(q_oe));
    jtag_host_model i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    task automatic check_vec(input string what, input logic [108:0] exp, input logic [108:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_vec(what, {108'h0, exp}, {108'h0, got});
    endtask
    task automatic final_report();
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // the old instruction must still stand while parked in exit1; only defined codes are passed in
    task automatic load_ir(input logic [2:0] code);
        logic q_before;
        q_before = q_oe;
        i_host.scan(1'b1, 3, {106'h0, code}, res);
        check_vec("ir capture", {106'h0, tap_pkg::IR_CAPTURE}, res);
        check_bit("q_oe while shifting", q_before, q_oe);
        check_bit("tdo_oe exit1", 1'b0, tdo_oe);
        i_host.upd();
    endtask
    task automatic read_id();
        i_host.scan(1'b0, 32, '0, res);
        check_vec("idcode", {77'h0, ID_EXP}, res);
        i_host.upd();
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (50000) @(posedge core_clk);
        n_errors++;
        final_report();
    end
    initial begin
        n_errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        ring_in = PAT;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check_bit("q_oe reset", 1'b1, q_oe);
        check_bit("drive_en reset", 1'b0, ring_drive_en);
        check_bit("tdo_oe reset", 1'b0, tdo_oe);
        // reset parks the controller in test-logic-reset; every scan starts from idle
        i_host.step(1'b0, 1'b0);
        read_id();
        // bypass: captured zero, then the bit fed in
        load_ir(tap_pkg::INS_BYPASS);
        i_host.scan(1'b0, 2, 109'h1, res);
        check_vec("bypass", 109'h2, res);
        i_host.upd();
        check_bit("q_oe bypass", 1'b1, q_oe);
        // sample then preload the inverse, control cell set
        load_ir(tap_pkg::INS_SAMPLE);
        i_host.scan(1'b0, 109, {1'b1, ~PAT}, res);
        check_vec("sample capture", {1'b0, PAT}, res);
        i_host.upd();
        check_vec("preload", {1'b0, ~PAT}, {1'b0, ring_drive});
        check_bit("q_oe sample", 1'b1, q_oe);
        // external test: read drivers follow the control cell
        @(posedge core_clk) #1 ring_in = ~PAT;
        load_ir(tap_pkg::INS_EXTEST);
        check_bit("drive_en extest", 1'b1, ring_drive_en);
        check_bit("q_oe cell set", 1'b1, q_oe);
        i_host.scan(1'b0, 109, {1'b0, PAT}, res);
        check_vec("extest capture", {1'b1, ~PAT}, res);
        i_host.upd();
        check_bit("q_oe cell clear", 1'b0, q_oe);
        // float mode holds drivers off even with the cell set
        load_ir(tap_pkg::INS_SAMPLEZ);
        check_bit("drive_en float", 1'b0, ring_drive_en);
        i_host.scan(1'b0, 109, {1'b1, PAT}, res);
        check_vec("float capture", {1'b0, ~PAT}, res);
        i_host.upd();
        check_bit("q_oe float", 1'b0, q_oe);
        // a tck pulse while frozen is lost, or the next load goes astray
        @(posedge core_clk) #1 clk_en = 1'b0;
        i_host.step(1'b1, 1'b0);
        @(posedge core_clk) #1 clk_en = 1'b1;
        load_ir(tap_pkg::INS_IDCODE);
        check_bit("q_oe idcode", 1'b1, q_oe);
        read_id();
        // test-logic-reset drops external test and brings back the code
        load_ir(tap_pkg::INS_EXTEST);
        i_host.tlr();
        check_bit("drive_en after tlr", 1'b0, ring_drive_en);
        read_id();
        final_report();
    end
endmodule // sram_boundary_scan_tap_tb
